// ---- rtl/rtcf_regs.sv ----
// RTC register file: flags, alarm, watchdog and interrupt pin
`timescale 1ns/10ps
`include "rtcf_defs.svh"

module rtcf_regs #(
  parameter int ADDR_W    = 17,
  parameter int DQ_W      = 8,
  parameter int PULSE_CYC = `RTCF_PULSE_MS * `RTCF_CLK_KHZ
) (
  // Clock, reset and enable
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_clk_en,
  // Parallel memory port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_ce_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  input  wire logic [DQ_W-1:0]   i_dq,
  output logic      [DQ_W-1:0]   o_dq,
  output logic                   o_dq_oe,
  // Event sources
  input  wire logic              i_tick_32hz,
  input  wire logic              i_power_fail,
  input  wire logic              i_osc_stopped,
  // Interrupt pin
  output logic                   o_int,
  output logic                   o_int_oe
);

  // ----------------------------------------------------------------------
  // Indexes and reset image
  // ----------------------------------------------------------------------
  // Low nibble of each offset is the register index
  localparam logic [3:0] IDX_FLAGS = 4'(`RTCF_OFF_FLAGS);
  localparam logic [3:0] IDX_CENT  = 4'(`RTCF_OFF_CENT);
  localparam logic [3:0] IDX_ASEC  = 4'(`RTCF_OFF_ASEC);
  localparam logic [3:0] IDX_AMIN  = 4'(`RTCF_OFF_AMIN);
  localparam logic [3:0] IDX_AHOUR = 4'(`RTCF_OFF_AHOUR);
  localparam logic [3:0] IDX_ADATE = 4'(`RTCF_OFF_ADATE);
  localparam logic [3:0] IDX_IRQ   = 4'(`RTCF_OFF_IRQ);
  localparam logic [3:0] IDX_WD    = 4'(`RTCF_OFF_WD);
  localparam logic [3:0] IDX_TRIM  = 4'(`RTCF_OFF_TRIM);
  localparam logic [3:0] IDX_SEC   = 4'(`RTCF_OFF_SEC);
  localparam logic [3:0] IDX_MIN   = 4'(`RTCF_OFF_MIN);
  localparam logic [3:0] IDX_HOUR  = 4'(`RTCF_OFF_HOUR);
  localparam logic [3:0] IDX_WEEK  = 4'(`RTCF_OFF_WEEK);
  localparam logic [3:0] IDX_DATE  = 4'(`RTCF_OFF_DATE);
  localparam logic [3:0] IDX_MON   = 4'(`RTCF_OFF_MON);
  localparam logic [3:0] IDX_YEAR  = 4'(`RTCF_OFF_YEAR);
  localparam int         PW        = rtcf_pkg::RTCF_PCNT_W;
  localparam logic [PW-1:0] PULSE_LD = PW'(PULSE_CYC);

  // Index 15 first, flags last
  localparam logic [15:0][7:0] RST_REGS = {
    `RTCF_RST_YEAR, `RTCF_RST_MON, `RTCF_RST_DATE, `RTCF_RST_WEEK,
    `RTCF_RST_HOUR, `RTCF_RST_MIN, `RTCF_RST_SEC, `RTCF_RST_TRIM,
    `RTCF_RST_WD, `RTCF_RST_IRQ, `RTCF_RST_ALARM, `RTCF_RST_ALARM,
    `RTCF_RST_ALARM, `RTCF_RST_ALARM, `RTCF_RST_CENT, `RTCF_RST_FLAGS};

  localparam rtcf_pkg::rtcf_state_t RST_STATE = '{
    bus:       rtcf_pkg::RTCF_BUS_IDLE,
    idx:       4'h0,
    wdat:      8'h00,
    regs:      RST_REGS,
    alarm_act: {4{`RTCF_RST_ALARM}},
    wd_cnt:    6'h00,
    match:     1'b0,
    pf:        1'b0,
    act:       1'b0,
    pcnt:      '0,
    dq:        8'h00,
    dq_oe:     1'b0,
    int_o:     1'b0,
    int_oe:    1'b0};

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // BCD digit pair inside a range; BCD order matches binary order
  function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  // Value acceptable for a BCD register; control bytes always pass
  function automatic logic wr_ok(input logic [3:0] i, input logic [7:0] v);
    logic [7:0] a;
    a = {1'b0, v[6:0]};
    case (i)
      IDX_CENT, IDX_YEAR: wr_ok = bcd_in(v, 8'h00, 8'h99);
      IDX_SEC, IDX_MIN:   wr_ok = bcd_in(v, 8'h00, 8'h59);
      IDX_HOUR:           wr_ok = bcd_in(v, 8'h00, 8'h23);
      IDX_WEEK:           wr_ok = bcd_in(v, 8'h01, 8'h07);
      IDX_DATE:           wr_ok = bcd_in(v, 8'h01, 8'h31);
      IDX_MON:            wr_ok = bcd_in(v, 8'h01, 8'h12);
      IDX_ASEC, IDX_AMIN: wr_ok = bcd_in(a, 8'h00, 8'h59);
      IDX_AHOUR:          wr_ok = bcd_in(a, 8'h00, 8'h23);
      IDX_ADATE:          wr_ok = bcd_in(a, 8'h01, 8'h31);
      default:            wr_ok = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------------
  rtcf_pkg::rtcf_state_t q;
  rtcf_pkg::rtcf_state_t d;
  logic                  hit;
  logic                  rd_flags;
  logic                  commit;
  logic                  wd_exp;
  logic                  al_set;
  logic                  pf_set;
  logic                  on;
  logic [5:0]            wd_val;
  logic                  match_w;

  // Alarm compare against the live time bytes
  rtcf_alarm_match u_match (
    .i_alarm (q.alarm_act),
    .i_time  ({q.regs[IDX_DATE], q.regs[IDX_HOUR], q.regs[IDX_MIN],
               q.regs[IDX_SEC]}),
    .o_match (match_w)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    d        = q;
    hit      = !i_ce_n && (&i_addr[ADDR_W-1:4]);
    rd_flags = 1'b0;
    commit   = 1'b0;
    wd_exp   = 1'b0;
    on       = 1'b0;
    wd_val   = q.regs[IDX_WD][5:0];

    // Watchdog down counter; a zero timeout disables it
    if (wd_val == 6'h00) begin
      d.wd_cnt = 6'h00;
    end else if (q.wd_cnt == 6'h00) begin
      d.wd_cnt = wd_val;
    end else if (i_tick_32hz) begin
      d.wd_cnt = q.wd_cnt - 6'h01;
      wd_exp   = (q.wd_cnt == 6'h01);
    end

    // Edges of alarm match and power monitor
    d.match = match_w;
    al_set  = match_w && !q.match;
    d.pf    = i_power_fail;
    pf_set  = i_power_fail && !q.pf;

    // Memory port; the write lands when the strobe ends
    unique case (q.bus)
      rtcf_pkg::RTCF_BUS_IDLE: begin
        if (hit && !i_we_n) begin
          d.bus  = rtcf_pkg::RTCF_BUS_WRITE;
          d.idx  = i_addr[3:0];
          d.wdat = i_dq[7:0];
        end else if (hit && !i_oe_n) begin
          d.bus    = rtcf_pkg::RTCF_BUS_READ;
          d.dq     = q.regs[i_addr[3:0]];
          d.dq_oe  = 1'b1;
          rd_flags = (i_addr[3:0] == IDX_FLAGS);
        end
      end
      rtcf_pkg::RTCF_BUS_READ: begin
        if (!(hit && !i_oe_n && i_we_n)) begin
          d.bus   = rtcf_pkg::RTCF_BUS_IDLE;
          d.dq_oe = 1'b0;
        end
      end
      rtcf_pkg::RTCF_BUS_WRITE: begin
        if (hit && !i_we_n) begin
          d.idx  = i_addr[3:0];
          d.wdat = i_dq[7:0];
        end else begin
          d.bus  = rtcf_pkg::RTCF_BUS_IDLE;
          commit = 1'b1;
        end
      end
      default: begin
        d.bus   = rtcf_pkg::RTCF_BUS_IDLE;
        d.dq_oe = 1'b0;
      end
    endcase

    // Register write; reserved bits are forced to zero
    if (commit) begin
      case (q.idx)
        IDX_FLAGS: begin
          d.regs[IDX_FLAGS][`RTCF_F_OSCILLATOR_STOPPED_FLAG] = q.regs[IDX_FLAGS][`RTCF_F_OSCILLATOR_STOPPED_FLAG]
                                            & q.wdat[`RTCF_F_OSCILLATOR_STOPPED_FLAG];
          d.regs[IDX_FLAGS][`RTCF_F_CAL] = q.wdat[`RTCF_F_CAL];
          d.regs[IDX_FLAGS][`RTCF_F_W]   = q.wdat[`RTCF_F_W];
          d.regs[IDX_FLAGS][`RTCF_F_R]   = q.wdat[`RTCF_F_R];
          // New alarm values take effect as the write bit drops
          if (q.regs[IDX_FLAGS][`RTCF_F_W] && !q.wdat[`RTCF_F_W]) begin
            d.alarm_act = q.regs[IDX_ADATE:IDX_ASEC];
          end
        end
        IDX_ASEC, IDX_AMIN, IDX_AHOUR, IDX_ADATE: begin
          if (q.regs[IDX_FLAGS][`RTCF_F_W] && wr_ok(q.idx, q.wdat)) begin
            d.regs[q.idx] = q.wdat;
          end
        end
        IDX_IRQ: begin
          d.regs[IDX_IRQ] = q.wdat & `RTCF_MASK_IRQ;
        end
        IDX_WD: begin
          d.regs[IDX_WD][`RTCF_F_WDW] = q.wdat[`RTCF_F_WDW];
          if (!q.wdat[`RTCF_F_WDW]) begin
            d.regs[IDX_WD][5:0] = q.wdat[5:0];
          end
          // Strobe reloads the count and never reads back as one
          if (q.wdat[`RTCF_F_WDS]) begin
            d.wd_cnt = d.regs[IDX_WD][5:0];
          end
        end
        IDX_TRIM: begin
          d.regs[IDX_TRIM] = q.wdat & `RTCF_MASK_TRIM;
        end
        default: begin
          if (wr_ok(q.idx, q.wdat)) begin
            d.regs[q.idx] = q.wdat;
          end
        end
      endcase
    end

    // Event flags: a set in the clearing cycle wins
    d.regs[IDX_FLAGS][`RTCF_F_WDF] = (q.regs[IDX_FLAGS][`RTCF_F_WDF] & !rd_flags)
                                     | wd_exp;
    d.regs[IDX_FLAGS][`RTCF_F_AF]  = (q.regs[IDX_FLAGS][`RTCF_F_AF] & !rd_flags)
                                     | al_set;
    d.regs[IDX_FLAGS][`RTCF_F_PF]  = (q.regs[IDX_FLAGS][`RTCF_F_PF] & !rd_flags)
                                     | pf_set;
    d.regs[IDX_FLAGS][`RTCF_F_OSCILLATOR_STOPPED_FLAG] = d.regs[IDX_FLAGS][`RTCF_F_OSCILLATOR_STOPPED_FLAG]
                                      | i_osc_stopped;
    d.regs[IDX_FLAGS][3] = 1'b0;

    // Interrupt source: a flag with its enable
    d.act = |(d.regs[IDX_FLAGS][7:5] & q.regs[IDX_IRQ][7:5]);

    // Pulse mode starts on a new source and ends early on a flags read
    if (q.regs[IDX_IRQ][`RTCF_F_PL]) begin
      if (d.act && !q.act) begin
        d.pcnt = PULSE_LD;
      end else if (q.pcnt != '0) begin
        d.pcnt = q.pcnt - PW'(1);
      end
      if (rd_flags) begin
        d.pcnt = '0;
      end
      on = (d.pcnt != '0);
    end else begin
      d.pcnt = '0;
      on     = d.act;
    end

    // High polarity is push-pull, low polarity is open drain
    if (d.regs[IDX_IRQ][`RTCF_F_HL]) begin
      d.int_o  = on;
      d.int_oe = 1'b1;
    end else begin
      d.int_o  = 1'b0;
      d.int_oe = on;
    end
  end

  // ----------------------------------------------------------------------
  // State register; enable low freezes everything
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= RST_STATE;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // Upper byte of a wide port always reads zero
  assign o_dq     = DQ_W'(q.dq);
  assign o_dq_oe  = q.dq_oe;
  assign o_int    = q.int_o;
  assign o_int_oe = q.int_oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_rd_clear;
    i_clk_en && rd_flags && !wd_exp && !al_set && !pf_set
      |=> q.regs[IDX_FLAGS][7:5] == 3'b000;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared");

  property p_pf_set;
    i_clk_en && $rose(i_power_fail) && !$past(i_rst)
      |-> ##1 q.regs[IDX_FLAGS][`RTCF_F_PF];
  endproperty
  a_pf_set: assert property (p_pf_set) else $error("power fail flag missed");

  property p_wd_set;
    i_clk_en && wd_exp |=> q.regs[IDX_FLAGS][`RTCF_F_WDF] && q.wd_cnt == 6'h00;
  endproperty
  a_wd_set: assert property (p_wd_set) else $error("watchdog flag missed");

  property p_int_level;
    i_clk_en && !commit && q.regs[IDX_IRQ][`RTCF_F_HL] && !q.regs[IDX_IRQ][`RTCF_F_PL]
      |=> o_int == (|(q.regs[IDX_FLAGS][7:5] & q.regs[IDX_IRQ][7:5]));
  endproperty
  a_int_level: assert property (p_int_level) else $error("level pin wrong");

  property p_lock;
    i_clk_en && commit && q.idx == IDX_WD && q.wdat[`RTCF_F_WDW] |=> $stable(wd_val);
  endproperty
  a_lock: assert property (p_lock) else $error("locked timeout changed");

  property p_alarm_off;
    q.alarm_act[0][7] && q.alarm_act[1][7] && q.alarm_act[2][7] && q.alarm_act[3][7]
      |-> !match_w && !al_set;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("masked alarm fired");

  property p_bcd_sec;
    q.regs[IDX_SEC][3:0] <= 4'h9 && q.regs[IDX_SEC] <= 8'h59 && q.regs[IDX_DATE] != 8'h00;
  endproperty
  a_bcd_sec: assert property (p_bcd_sec) else $error("time byte out of range");

  property p_irq_rsv;
    (q.regs[IDX_IRQ] & ~`RTCF_MASK_IRQ) == 8'h00 && q.regs[IDX_FLAGS][3] == 1'b0;
  endproperty
  a_irq_rsv: assert property (p_irq_rsv) else $error("reserved bit set");

  property p_rst_vals;
    $past(i_rst) |-> q.regs[IDX_IRQ] == `RTCF_RST_IRQ && q.regs[IDX_ASEC] == `RTCF_RST_ALARM
      && q.regs[IDX_WD] == `RTCF_RST_WD && q.regs[IDX_FLAGS][7:5] == 3'b000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad value after reset");

  property p_upper;
    (o_dq >> 8) == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper byte driven");

  c_rd_wdf: cover property (rd_flags && q.regs[IDX_FLAGS][`RTCF_F_WDF]);
  c_pulse:  cover property (o_int_oe && q.regs[IDX_IRQ][`RTCF_F_PL] && q.pcnt != '0);
  c_alarm:  cover property (i_clk_en && al_set);

endmodule // rtcf_regs

// ---- rtl/rtcf_defs.svh ----
// Offsets, field positions, reset values and timing of the RTC register file
// What this block does
// - Flags byte holds watchdog, alarm, power-fail flags
// - Events set their flags in hardware
// - Reading the flags byte clears watchdog, alarm and power-fail flags
// - Flags byte resets to zero, oscillator flag included
// - Upper data byte is reserved when sixteen wide
// - Control bytes binary, time and alarm BCD
// - Control bytes take their shipped defaults
// - Alarm bytes carry match bit seven
// - Interrupt byte holds enables, polarity, pulse select
// - Alarm field compares only when match bit zero
// - Interrupt needs a set flag and enable
// - Write lock protects the watchdog timeout value
`ifndef RTCF_DEFS_SVH
`define RTCF_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTCF_OFF_FLAGS  17'h1fff0
`define RTCF_OFF_CENT   17'h1fff1
`define RTCF_OFF_ASEC   17'h1fff2
`define RTCF_OFF_AMIN   17'h1fff3
`define RTCF_OFF_AHOUR  17'h1fff4
`define RTCF_OFF_ADATE  17'h1fff5
`define RTCF_OFF_IRQ    17'h1fff6
`define RTCF_OFF_WD     17'h1fff7
`define RTCF_OFF_TRIM   17'h1fff8
`define RTCF_OFF_SEC    17'h1fff9
`define RTCF_OFF_MIN    17'h1fffa
`define RTCF_OFF_HOUR   17'h1fffb
`define RTCF_OFF_WEEK   17'h1fffc
`define RTCF_OFF_DATE   17'h1fffd
`define RTCF_OFF_MON    17'h1fffe
`define RTCF_OFF_YEAR   17'h1ffff

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTCF_F_WDF      7
`define RTCF_F_AF       6
`define RTCF_F_PF       5
`define RTCF_F_OSCILLATOR_STOPPED_FLAG     4
`define RTCF_F_CAL      2
`define RTCF_F_W        1
`define RTCF_F_R        0
`define RTCF_F_HL       3
`define RTCF_F_PL       2
`define RTCF_F_WDS      7
`define RTCF_F_WDW      6
`define RTCF_F_MATCH    7
`define RTCF_MASK_IRQ   8'hec
`define RTCF_MASK_TRIM  8'hbf

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTCF_RST_FLAGS  8'h00
`define RTCF_RST_CENT   8'h00
`define RTCF_RST_ALARM  8'h80
`define RTCF_RST_IRQ    8'h08
`define RTCF_RST_WD     8'h00
`define RTCF_RST_TRIM   8'h00
`define RTCF_RST_SEC    8'h00
`define RTCF_RST_MIN    8'h00
`define RTCF_RST_HOUR   8'h00
`define RTCF_RST_WEEK   8'h01
`define RTCF_RST_DATE   8'h01
`define RTCF_RST_MON    8'h01
`define RTCF_RST_YEAR   8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTCF_PULSE_MS   200
`define RTCF_CLK_KHZ    100000

`endif

// ---- rtl/rtcf_pkg.sv ----
// Types shared by the RTC register file modules
package rtcf_pkg;

  // Width of the interrupt pulse counter
  localparam int RTCF_PCNT_W = 25;

  // Memory port access state
  typedef enum logic [1:0] {
    RTCF_BUS_IDLE  = 2'b00,
    RTCF_BUS_READ  = 2'b01,
    RTCF_BUS_WRITE = 2'b10
  } rtcf_bus_t;

  // Whole state of the register file
  typedef struct packed {
    rtcf_bus_t              bus;
    logic [3:0]             idx;
    logic [7:0]             wdat;
    logic [15:0][7:0]       regs;
    logic [3:0][7:0]        alarm_act;
    logic [5:0]             wd_cnt;
    logic                   match;
    logic                   pf;
    logic                   act;
    logic [RTCF_PCNT_W-1:0] pcnt;
    logic [7:0]             dq;
    logic                   dq_oe;
    logic                   int_o;
    logic                   int_oe;
  } rtcf_state_t;

endpackage

// ---- rtl/rtcf_alarm_match.sv ----
// Alarm comparator: masked compare of alarm fields against the time
`timescale 1ns/10ps
`include "rtcf_defs.svh"

module rtcf_alarm_match (
  // Alarm and time bytes: 0 seconds, 1 minutes, 2 hours, 3 date
  input  wire logic [3:0][7:0] i_alarm,
  input  wire logic [3:0][7:0] i_time,
  // Compare result
  output logic                 o_match
);

  logic [3:0] ok;
  logic [3:0] masked;

  // Field joins the compare only with its match bit low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      masked[i] = i_alarm[i][`RTCF_F_MATCH];
      ok[i]     = masked[i] || (i_alarm[i][6:0] == i_time[i][6:0]);
    end
    o_match = (&ok) && !(&masked);
  end

endmodule // rtcf_alarm_match

// ---- verif/rtcf_host_model.sv ----
// Host processor model driving the parallel memory port
`timescale 1ns/10ps

module rtcf_host_model (
  // Clock
  input  wire logic        i_clk,
  // Memory port toward the register file
  output logic [16:0]      o_addr,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic [7:0]       o_dq,
  input  wire logic        i_dq_oe
);
  // Idle bus at time zero
  initial begin
    o_addr = 17'h00000;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
    o_dq   = 8'h00;
  end

  // Released lines flip so a stale value never looks valid
  task automatic release_bus();
    o_ce_n <= 1'b1;
    o_oe_n <= 1'b1;
    o_we_n <= 1'b1;
    o_addr <= ~o_addr;
    o_dq   <= ~o_dq;
  endtask

  // Byte write: one edge low, released edge commits
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= {13'h1fff, idx};
    o_dq   <= d;
    o_ce_n <= 1'b0;
    o_we_n <= 1'b0;
    @(posedge i_clk);
    release_bus();
    @(posedge i_clk);
  endtask

  // Byte read: hold until the data enable is seen, bounded
  task automatic rd(input logic [3:0] idx);
    int n;
    @(posedge i_clk);
    o_addr <= {13'h1fff, idx};
    o_ce_n <= 1'b0;
    o_oe_n <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_dq_oe !== 1'b1 && n < 8);
    release_bus();
  endtask
endmodule // rtcf_host_model

// ---- verif/rtc_flags_and_register_map_tb.sv ----
// Self-checking bench for the RTC register file
`timescale 1ns/10ps

module rtc_flags_and_register_map_tb;
  localparam int PULSE = 20;
  logic        i_clk, i_rst, ce_n, oe_n, we_n, dq_oe, tick, pfail, oscs, int_pin, int_oe;
  logic        clk_en;
  logic [16:0] addr;
  logic [7:0]  dq_w, dq_r, b;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic        oe_prev;
  int          n_fail, n_tests, v, r;
  logic [7:0]  rst_tab [16] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h08, 8'h00,
                                8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

  // Clock, 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Short pulse length keeps the pulse-mode test quick
  rtcf_regs #(.PULSE_CYC(PULSE)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_clk_en(clk_en), .i_addr(addr), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq_w), .o_dq(dq_r), .o_dq_oe(dq_oe),
    .i_tick_32hz(tick), .i_power_fail(pfail), .i_osc_stopped(oscs),
    .o_int(int_pin), .o_int_oe(int_oe));

  rtcf_host_model h (
    .i_clk(i_clk), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_dq(dq_w), .i_dq_oe(dq_oe));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (exp_q.size() != 0) n_fail++;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Note the masked expectation, then read
  task automatic rd(input logic [3:0] idx, input logic [7:0] x, input logic [7:0] m = 8'hff);
    exp_q.push_back({m, x & m});
    h.rd(idx);
  endtask

  // Pin level and enable a few edges after an event
  task automatic pin(input logic lvl);
    repeat (3) @(posedge i_clk);
    #1;
    check({6'h00, int_oe, int_pin}, {6'h00, 1'b1, lvl});
  endtask

  task automatic pf_event();
    @(posedge i_clk);
    pfail <= 1'b1;
    repeat (3) @(posedge i_clk);
    pfail <= 1'b0;
  endtask

  // Read monitor: oldest note against each new read result
  always @(posedge i_clk) begin
    if (dq_oe === 1'b1 && oe_prev !== 1'b1) begin
      e = exp_q.pop_front();
      check(dq_r & e[15:8], e[7:0]);
    end
    oe_prev = dq_oe;
  end

  // Hang guard, well beyond the expected run
  initial begin
    #50000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin
    tick = 1'b0;
    clk_en = 1'b1;
    pfail = 1'b0;
    oscs = 1'b0;
    i_rst = 1'b1;
    n_fail = 0;
    n_tests = 0;
    r = $urandom(32'h591f1631);
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 16; k++) rd(k[3:0], rst_tab[k]);
    $display("Test reset values done");
    // Random legal minutes kept, out-of-range bytes dropped whole
    for (int k = 0; k < 4; k++) begin
      v = $urandom % 60;
      b = 8'((v / 10) * 16 + v % 10);
      h.wr(4'ha, b);
      h.wr(4'ha, 8'h60);
      rd(4'ha, b);
    end
    h.wr(4'hb, 8'h24);
    rd(4'hb, 8'h00);
    h.wr(4'h9, 8'h15);
    rd(4'h0, 8'h00);
    h.wr(4'h6, 8'hff);
    rd(4'h6, 8'hec);
    h.wr(4'h8, 8'hff);
    rd(4'h8, 8'hbf);
    h.wr(4'h8, 8'h00);
    $display("Test ranges and reserved bits done");
    h.wr(4'h6, 8'h28);
    pf_event();
    pin(1'b1);
    rd(4'h0, 8'h20);
    pin(1'b0);
    rd(4'h0, 8'h00);
    h.wr(4'h6, 8'h08);
    pf_event();
    pin(1'b0);
    rd(4'h0, 8'h20);
    h.wr(4'h6, 8'h2c);
    pf_event();
    pin(1'b1);
    repeat (PULSE) @(posedge i_clk);
    pin(1'b0);
    rd(4'h0, 8'h20);
    $display("Test power fail done");
    h.wr(4'h6, 8'h88);
    h.wr(4'h7, 8'h83);
    repeat (3) begin
      @(posedge i_clk);
      tick <= 1'b1;
      @(posedge i_clk);
      tick <= 1'b0;
    end
    pin(1'b1);
    rd(4'h0, 8'h80);
    h.wr(4'h7, 8'h45);
    rd(4'h7, 8'h03, 8'h3f);
    $display("Test watchdog done");
    h.wr(4'h3, 8'h30);
    rd(4'h3, 8'h80);
    h.wr(4'h0, 8'h02);
    h.wr(4'h5, 8'h32);
    h.wr(4'h2, 8'h15);
    h.wr(4'h0, 8'h00);
    rd(4'h5, 8'h80);
    h.wr(4'h6, 8'h48);
    h.wr(4'h9, 8'h00);
    h.wr(4'h9, 8'h15);
    pin(1'b1);
    rd(4'h0, 8'h40);
    // Low polarity: open drain, enable carries the active state
    h.wr(4'h6, 8'h20);
    pf_event();
    pin(1'b0);
    rd(4'h0, 8'h20);
    $display("Test alarm done");
    @(posedge i_clk);
    oscs <= 1'b1;
    @(posedge i_clk);
    oscs <= 1'b0;
    rd(4'h0, 8'h10);
    rd(4'h0, 8'h10);
    h.wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    $display("Test oscillator flag done");
    // Frozen block must miss a power-fail pulse entirely
    @(posedge i_clk);
    clk_en <= 1'b0;
    pf_event();
    repeat (2) @(posedge i_clk);
    clk_en <= 1'b1;
    rd(4'h0, 8'h00);
    $display("Test clock enable done");
    repeat (4) @(posedge i_clk);
    final_report();
  end
endmodule // rtc_flags_and_register_map_tb
